// *** logic/lsse_pkg.sv ***
// Shared constants and types for the loop start-up, scrambler and operations-channel block.
package lsse_pkg;
    localparam int CLOCK_HZ = 250_000_000;
    localparam int SYM_RATE_HZ = 80_000;
    localparam int SYM_CYCLES = CLOCK_HZ / SYM_RATE_HZ;
    localparam int RX_RESET_MS = 40;
    localparam int RX_RESET_CYCLES = (CLOCK_HZ / 1000) * RX_RESET_MS;
    localparam int TONE_HALF = 4;
    localparam int TONE_SYMBOLS = 720;
    localparam logic [1:0] SYM_POS3 = 2'h2;
    localparam logic [1:0] SYM_NEG3 = 2'h0;
    localparam logic [22:0] SCR_SEED = 23'h000001;
    localparam int TX_TAP = 18;
    localparam int RX_TAP = 5;
    localparam int LONG_TAP = 23;
    localparam logic [2:0] ADDR_SELF = 3'h0;
    localparam logic [2:0] ADDR_BCAST = 3'h7;
    localparam logic [7:0] EOC_LOOP_ALL = 8'h50;
    localparam logic [7:0] EOC_LOOP_B1 = 8'h51;
    localparam logic [7:0] EOC_LOOP_B2 = 8'h52;
    localparam logic [7:0] EOC_REQ_CRC = 8'h53;
    localparam logic [7:0] EOC_NOTIFY_CRC = 8'h54;
    localparam logic [7:0] EOC_RETURN = 8'hff;
    localparam logic [7:0] EOC_HOLD = 8'h00;
    localparam logic [7:0] EOC_UNABLE = 8'haa;
    localparam logic [3:0] NONSTD_A = 4'h4;
    localparam logic [3:0] NONSTD_B = 4'h3;
    localparam logic [3:0] NONSTD_C = 4'h2;
    localparam logic [3:0] NONSTD_D = 4'h1;

    typedef struct packed {
        logic [2:0] addr;
        logic msg;
        logic [7:0] info;
    } lsse_eoc_t;

    typedef struct packed {
        logic fw;
        logic inverted_frame_word;
        logic ovh;
        logic b1;
        logic b2;
    } lsse_slot_t;

    typedef struct packed {
        logic on;
        logic [1:0] bits;
    } lsse_tx_t;

    typedef enum logic [7:0] {
        ST_FULL_RESET = 8'h01,
        ST_WAKE_TONE = 8'h02,
        ST_PATTERN1 = 8'h04,
        ST_SILENT = 8'h08,
        ST_WAIT_PAT2 = 8'h10,
        ST_PATTERN2 = 8'h20,
        ST_NORMAL = 8'h40,
        ST_RECV_RESET = 8'h80
    } lsse_state_t;
endpackage : lsse_pkg

// *** logic/lsse_customer_terminal.sv ***
// Customer-side terminal: start-up control, scrambling and operations-channel decoding.
`timescale 1ns/10ps
module lsse_customer_terminal import lsse_pkg::*; #(
    parameter int RX_RESET_LEN = RX_RESET_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Activation inputs.
    input wire logic service_request,
    input wire logic sig_detect,
    input wire logic wake_tone_detect,
    input wire logic ready_to_receive,
    input wire logic frame_locked,
    input wire logic pattern2_detect,
    input wire logic mf_locked,
    input wire logic transparent,
    // Transmit side.
    input wire lsse_slot_t tx_slot,
    input wire logic [1:0] tx_user,
    input wire logic [1:0] tx_ovh,
    input wire logic [1:0] tx_fw,
    output logic tx_strobe,
    output lsse_tx_t tx_line,
    // Receive side.
    input wire logic rx_valid,
    input wire logic rx_fw_slot,
    input wire logic [1:0] rx_bits,
    output logic [1:0] rx_data,
    // Operations channel.
    input wire logic eoc_valid,
    input wire lsse_eoc_t eoc_rx,
    output lsse_eoc_t eoc_reply,
    output logic eoc_reply_valid,
    output logic [4:0] eoc_latched,
    // Status.
    output lsse_state_t state
);
    lsse_state_t next_state;
    logic [11:0] sym_cnt;
    logic [15:0] tone_cnt;
    logic [23:0] rr_cnt;
    logic tone_seen;
    logic [22:0] tx_sr;
    logic [22:0] rx_sr;
    logic [22:0] tx_sr_a;
    logic [22:0] rx_sr_a;
    logic [1:0] scr_out;
    logic [1:0] dsc_out;
    logic [1:0] src_bits;
    logic early;
    lsse_eoc_t eoc_prev;
    logic [1:0] eoc_cnt;
    logic [1:0] next_cnt;
    logic addr_ok;
    logic known;
    logic nonstd;

    // Symbol pacing from the system clock.
    always_ff @(posedge clock) begin
        if (sys_rst || sym_cnt == 12'(SYM_CYCLES - 1)) begin
            sym_cnt <= 12'h000;
        end else begin
            sym_cnt <= sym_cnt + 12'h001;
        end
    end
    assign tx_strobe = (sym_cnt == 12'(SYM_CYCLES - 1));

    // Start-up sequencing.
    always_comb begin
        next_state = state;
        case (state)
            ST_FULL_RESET: begin
                if (service_request || wake_tone_detect || tone_seen) begin
                    next_state = ST_WAKE_TONE;
                end
            end
            ST_WAKE_TONE: if (tx_strobe && tone_cnt == 16'(TONE_SYMBOLS - 1)) next_state = ST_PATTERN1;
            ST_PATTERN1: if (ready_to_receive) next_state = ST_SILENT;
            ST_SILENT: if (sig_detect) next_state = ST_WAIT_PAT2;
            ST_WAIT_PAT2: begin
                if (!sig_detect) begin
                    next_state = ST_RECV_RESET;
                end else if (frame_locked && pattern2_detect) begin
                    next_state = ST_PATTERN2;
                end
            end
            ST_PATTERN2: begin
                if (!sig_detect) begin
                    next_state = ST_RECV_RESET;
                end else if (mf_locked) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_NORMAL: if (!sig_detect) next_state = ST_RECV_RESET;
            ST_RECV_RESET: if (rr_cnt == 24'(RX_RESET_LEN - 1)) next_state = ST_FULL_RESET;
            default: next_state = ST_FULL_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_FULL_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Receive-reset dwell and wake tone capture.
    always_ff @(posedge clock) begin
        if (sys_rst || state != ST_RECV_RESET) begin
            rr_cnt <= 24'h000000;
        end else begin
            rr_cnt <= rr_cnt + 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || state == ST_WAKE_TONE) begin
            tone_seen <= 1'b0;
        end else if (state == ST_RECV_RESET && wake_tone_detect) begin
            tone_seen <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || state != ST_WAKE_TONE) begin
            tone_cnt <= 16'h0000;
        end else if (tx_strobe) begin
            tone_cnt <= tone_cnt + 16'h0001;
        end
    end

    // Transmit bit source.
    assign early = (state == ST_PATTERN1) || (state == ST_PATTERN2);
    always_comb begin
        src_bits = 2'h3;
        if (state == ST_NORMAL) begin
            if (tx_slot.ovh) begin
                src_bits = tx_ovh;
            end else if (eoc_latched[0] || (eoc_latched[1] && tx_slot.b1) || (eoc_latched[2] && tx_slot.b2)) begin
                src_bits = rx_data;
            end else if (transparent) begin
                src_bits = tx_user;
            end else begin
                src_bits = 2'h3;
            end
        end
    end

    // Scrambler, two bits per symbol, newest bit in position zero.
    always_comb begin
        scr_out[1] = src_bits[1] ^ tx_sr[TX_TAP - 1] ^ tx_sr[LONG_TAP - 1];
        tx_sr_a = {tx_sr[21:0], scr_out[1]};
        scr_out[0] = src_bits[0] ^ tx_sr_a[TX_TAP - 1] ^ tx_sr_a[LONG_TAP - 1];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_sr <= SCR_SEED;
        end else if (tx_strobe && !tx_slot.fw && !tx_slot.inverted_frame_word && (early || state == ST_NORMAL)) begin
            tx_sr <= {tx_sr_a[21:0], scr_out[0]};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_line <= '0;
        end else if (tx_strobe || !(early || state == ST_WAKE_TONE || state == ST_NORMAL)) begin
            tx_line.on <= 1'b0;
            tx_line.bits <= SYM_NEG3;
            if (state == ST_WAKE_TONE) begin
                tx_line.on <= 1'b1;
                tx_line.bits <= ((tone_cnt % 16'(2 * TONE_HALF)) < 16'(TONE_HALF)) ? SYM_POS3 : SYM_NEG3;
            end else if (early || state == ST_NORMAL) begin
                tx_line.on <= 1'b1;
                if (tx_slot.fw || (tx_slot.inverted_frame_word && early)) begin
                    tx_line.bits <= tx_fw;
                end else if (tx_slot.inverted_frame_word) begin
                    tx_line.bits <= ~tx_fw;
                end else begin
                    tx_line.bits <= scr_out;
                end
            end
        end
    end

    // Descrambler for the network direction.
    always_comb begin
        dsc_out[1] = rx_bits[1] ^ rx_sr[RX_TAP - 1] ^ rx_sr[LONG_TAP - 1];
        rx_sr_a = {rx_sr[21:0], rx_bits[1]};
        dsc_out[0] = rx_bits[0] ^ rx_sr_a[RX_TAP - 1] ^ rx_sr_a[LONG_TAP - 1];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_sr <= SCR_SEED;
            rx_data <= 2'h0;
        end else if (rx_valid && !rx_fw_slot) begin
            rx_sr <= {rx_sr_a[21:0], rx_bits[0]};
            rx_data <= dsc_out;
        end
    end

    // Operations channel decode.
    assign addr_ok = (eoc_rx.addr == ADDR_SELF) || (eoc_rx.addr == ADDR_BCAST);
    assign nonstd = eoc_rx.info[7:4] == NONSTD_A || eoc_rx.info[7:4] == NONSTD_B
        || eoc_rx.info[7:4] == NONSTD_C || eoc_rx.info[7:4] == NONSTD_D;
    always_comb begin
        case (eoc_rx.info)
            EOC_LOOP_ALL, EOC_LOOP_B1, EOC_LOOP_B2: known = 1'b1;
            EOC_REQ_CRC, EOC_NOTIFY_CRC: known = 1'b1;
            EOC_RETURN, EOC_HOLD: known = 1'b1;
            default: known = 1'b0;
        endcase
        known = known && !nonstd;
        if (eoc_rx != eoc_prev || eoc_cnt == 2'h0) begin
            next_cnt = 2'h1;
        end else if (eoc_cnt == 2'h3) begin
            next_cnt = 2'h3;
        end else begin
            next_cnt = eoc_cnt + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            eoc_prev <= '0;
            eoc_cnt <= 2'h0;
        end else if (eoc_valid) begin
            eoc_prev <= eoc_rx;
            eoc_cnt <= addr_ok ? next_cnt : 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            eoc_latched <= 5'h00;
        end else if (eoc_valid && addr_ok && eoc_rx.msg && known && next_cnt == 2'h3) begin
            case (eoc_rx.info)
                EOC_LOOP_ALL: eoc_latched[0] <= 1'b1;
                EOC_LOOP_B1: eoc_latched[1] <= 1'b1;
                EOC_LOOP_B2: eoc_latched[2] <= 1'b1;
                EOC_REQ_CRC: eoc_latched[3] <= 1'b1;
                EOC_NOTIFY_CRC: eoc_latched[4] <= 1'b1;
                EOC_RETURN: eoc_latched <= 5'h00;
                default: eoc_latched <= eoc_latched;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            eoc_reply <= '0;
            eoc_reply_valid <= 1'b0;
        end else begin
            eoc_reply_valid <= eoc_valid;
            if (eoc_valid) begin
                eoc_reply <= eoc_rx;
                if (!addr_ok) begin
                    eoc_reply <= {ADDR_SELF, 1'b1, EOC_HOLD};
                end else if (eoc_rx.msg && !known && next_cnt == 2'h3) begin
                    eoc_reply <= {ADDR_SELF, 1'b1, EOC_UNABLE};
                end
            end
        end
    end

    // Checks.
    sequence s_dwell_done;
        $past(state) == ST_RECV_RESET && state == ST_FULL_RESET;
    endsequence
    sequence s_third_copy;
        eoc_valid && addr_ok && eoc_rx.msg && eoc_rx.info == EOC_LOOP_ALL && next_cnt == 2'h3;
    endsequence

    a_dwell_length: assert property (@(posedge clock) disable iff (sys_rst)
        s_dwell_done |-> $past(rr_cnt) == 24'(RX_RESET_LEN - 1))
        else $error("receive reset left early");
    a_reset_silent: assert property (@(posedge clock) disable iff (sys_rst)
        (state == ST_FULL_RESET || state == ST_RECV_RESET || state == ST_SILENT)
        ##1 (state == ST_FULL_RESET || state == ST_RECV_RESET || state == ST_SILENT)
        |-> !tx_line.on)
        else $error("transmitting while in reset");
    a_cold_start: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(state == ST_WAKE_TONE) |-> $past(state) == ST_FULL_RESET)
        else $error("start-up not from full reset");
    a_strobe_rate: assert property (@(posedge clock) disable iff (sys_rst)
        tx_strobe |-> ##1 !tx_strobe [*8])
        else $error("symbol strobe too fast");
    a_tx_hold_fw: assert property (@(posedge clock) disable iff (sys_rst)
        tx_strobe && tx_slot.fw |=> $stable(tx_sr))
        else $error("scrambler advanced in frame word");
    a_rx_hold_fw: assert property (@(posedge clock) disable iff (sys_rst)
        rx_valid && rx_fw_slot |=> $stable(rx_sr))
        else $error("descrambler advanced in frame word");
    a_loop_latch: assert property (@(posedge clock) disable iff (sys_rst)
        s_third_copy |=> eoc_latched[0])
        else $error("loopback not latched on third copy");
    a_no_early_act: assert property (@(posedge clock) disable iff (sys_rst)
        eoc_valid && next_cnt != 2'h3 && !eoc_latched[0] |=> !eoc_latched[0])
        else $error("loopback latched too early");
    a_wrong_addr: assert property (@(posedge clock) disable iff (sys_rst)
        eoc_valid && !addr_ok |=> eoc_reply_valid && eoc_reply == {ADDR_SELF, 1'b1, EOC_HOLD})
        else $error("bad address not answered with hold");
    a_pat2_entry: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(state == ST_PATTERN2) |-> $past(frame_locked) && $past(pattern2_detect))
        else $error("pattern two without lock");
    a_fw_in_early: assert property (@(posedge clock) disable iff (sys_rst)
        tx_strobe && early && tx_slot.inverted_frame_word |=> tx_line.bits == $past(tx_fw))
        else $error("inverted frame word sent in early pattern");
endmodule : lsse_customer_terminal

// *** test/lsse_net_model.sv ***
// Far-end network transceiver model that scrambles symbols sent toward the terminal.
`timescale 1ns/10ps
module lsse_net_model import lsse_pkg::*; (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Symbol request from the bench.
    input wire logic send,
    input wire logic send_fw,
    input wire logic [1:0] send_bits,
    // Line toward the terminal.
    output logic rx_valid,
    output logic rx_fw_slot,
    output logic [1:0] rx_bits
);
    logic [22:0] sr;
    logic [22:0] t;
    logic a;
    logic b;
    always_comb begin
        a = send_bits[1] ^ sr[RX_TAP - 1] ^ sr[LONG_TAP - 1];
        t = {sr[21:0], a};
        b = send_bits[0] ^ t[RX_TAP - 1] ^ t[LONG_TAP - 1];
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sr <= SCR_SEED;
            rx_bits <= 2'h0;
        end else if (send && !send_fw) begin
            sr <= {t[21:0], b};
            rx_bits <= {a, b};
        end else begin
            rx_bits <= send ? send_bits : ~rx_bits;
        end
    end
    always_ff @(posedge clock) begin
        rx_valid <= send && !sys_rst;
        rx_fw_slot <= send && send_fw && !sys_rst;
    end
endmodule : lsse_net_model

// *** test/lsse_customer_terminal_tb.sv ***
// Self-checking bench for the customer-side terminal.
`timescale 1ns/10ps
module lsse_customer_terminal_tb import lsse_pkg::*;;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic service_request = 1'b0;
    logic sig_detect = 1'b0, wake_tone_detect = 1'b0, ready_to_receive = 1'b0, frame_locked = 1'b0;
    logic pattern2_detect = 1'b0, mf_locked = 1'b0, transparent = 1'b0;
    lsse_slot_t tx_slot = '0;
    logic [1:0] tx_user = 2'h0, tx_ovh = 2'h0, tx_fw = 2'h0, send_bits = 2'h0, rx_bits, rx_data;
    logic send = 1'b0, send_fw = 1'b0, eoc_valid = 1'b0, tx_strobe, rx_valid, rx_fw_slot, eoc_reply_valid;
    lsse_tx_t tx_line;
    lsse_eoc_t eoc_rx = '0;
    lsse_eoc_t eoc_reply;
    logic [4:0] eoc_latched;
    lsse_state_t state;
    int err_total = 0;
    int checks_done = 0;

    lsse_customer_terminal #(.RX_RESET_LEN(50)) i_lsse_customer_terminal (
        .clock(clock), .sys_rst(sys_rst), .service_request(service_request), .sig_detect(sig_detect),
        .wake_tone_detect(wake_tone_detect), .ready_to_receive(ready_to_receive), .frame_locked(frame_locked),
        .pattern2_detect(pattern2_detect), .mf_locked(mf_locked), .transparent(transparent), .tx_slot(tx_slot),
        .tx_user(tx_user), .tx_ovh(tx_ovh), .tx_fw(tx_fw), .tx_strobe(tx_strobe), .tx_line(tx_line),
        .rx_valid(rx_valid), .rx_fw_slot(rx_fw_slot), .rx_bits(rx_bits), .rx_data(rx_data), .eoc_valid(eoc_valid),
        .eoc_rx(eoc_rx), .eoc_reply(eoc_reply), .eoc_reply_valid(eoc_reply_valid), .eoc_latched(eoc_latched),
        .state(state));
    lsse_net_model i_lsse_net_model (.clock(clock), .sys_rst(sys_rst), .send(send), .send_fw(send_fw),
        .send_bits(send_bits), .rx_valid(rx_valid), .rx_fw_slot(rx_fw_slot), .rx_bits(rx_bits));

    initial begin
        forever #2 clock = ~clock;
    end

    task automatic conclude;
        $display("Checks made %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_st(input lsse_state_t exp);
        checks_done++;
        if (state !== exp) begin
            err_total++;
            $display("[ERR] state expected %h seen %h", exp, state);
        end
    endtask : chk_st

    task automatic wait_strobe(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (tx_strobe !== 1'b1 && n < 4000);
        @(posedge clock);
        #1;
    endtask : wait_strobe

    task automatic eoc_send(input lsse_eoc_t f);
        @(posedge clock);
        eoc_valid <= 1'b1;
        eoc_rx <= f;
        @(posedge clock);
        eoc_valid <= 1'b0;
        eoc_rx <= ~f;
        #1;
        chk_val("reply valid", 12'h001, 12'(eoc_reply_valid));
    endtask : eoc_send

    task automatic rx_sym(input logic fw, input logic [1:0] v, input bit cmp);
        @(posedge clock);
        send <= 1'b1;
        send_fw <= fw;
        send_bits <= v;
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        #1;
        if (cmp) chk_val("rx data", 12'(v), 12'(rx_data));
    endtask : rx_sym

    task automatic t_reset;
        int n;
        chk_st(ST_FULL_RESET);
        chk_val("latched", 12'h000, 12'(eoc_latched));
        wait_strobe(n);
        chk_val("first strobe", 12'(SYM_CYCLES - 1), 12'(n));
        chk_val("line idle", 12'h000, 12'(tx_line));
        chk_st(ST_FULL_RESET);
    endtask : t_reset

    task automatic t_eoc_codes;
        logic [7:0] codes [5] = '{EOC_LOOP_ALL, EOC_LOOP_B1, EOC_LOOP_B2, EOC_REQ_CRC, EOC_NOTIFY_CRC};
        lsse_eoc_t f;
        logic [4:0] e;
        e = 5'h00;
        for (int i = 0; i < 5; i++) begin
            f = '{(i % 2 == 1) ? ADDR_BCAST : ADDR_SELF, 1'b1, codes[i]};
            eoc_send(f);
            eoc_send(f);
            chk_val("latched early", 12'(e), 12'(eoc_latched));
            eoc_send(f);
            e[i] = 1'b1;
            chk_val("latched", 12'(e), 12'(eoc_latched));
            chk_val("echo", 12'(f), 12'(eoc_reply));
        end
        f = '{ADDR_SELF, 1'b1, EOC_RETURN};
        eoc_send(f);
        eoc_send(f);
        chk_val("latched held", 12'h01f, 12'(eoc_latched));
        eoc_send(f);
        chk_val("latched cleared", 12'h000, 12'(eoc_latched));
    endtask : t_eoc_codes

    task automatic t_eoc_refuse;
        logic [7:0] odd [6] = '{8'h60, 8'h45, 8'h3c, 8'h27, 8'h1f, EOC_UNABLE};
        lsse_eoc_t f;
        f = '{3'h2, 1'b1, EOC_LOOP_ALL};
        repeat (3) eoc_send(f);
        chk_val("hold reply", 12'(lsse_eoc_t'({ADDR_SELF, 1'b1, EOC_HOLD})), 12'(eoc_reply));
        for (int i = 0; i < 6; i++) begin
            f = '{ADDR_SELF, 1'b1, odd[i]};
            eoc_send(f);
            chk_val("first echo", 12'(f), 12'(eoc_reply));
            eoc_send(f);
            eoc_send(f);
            chk_val("unable reply", 12'(lsse_eoc_t'({ADDR_SELF, 1'b1, EOC_UNABLE})), 12'(eoc_reply));
        end
        f = '{ADDR_SELF, 1'b0, EOC_LOOP_ALL};
        repeat (3) eoc_send(f);
        chk_val("data echo", 12'(f), 12'(eoc_reply));
        chk_val("no action", 12'h000, 12'(eoc_latched));
    endtask : t_eoc_refuse

    task automatic t_midrst;
        lsse_eoc_t f;
        f = '{ADDR_BCAST, 1'b1, EOC_LOOP_B2};
        repeat (3) eoc_send(f);
        chk_val("latched before reset", 12'h004, 12'(eoc_latched));
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        chk_val("latched after reset", 12'h000, 12'(eoc_latched));
        chk_val("line after reset", 12'h000, 12'(tx_line));
        chk_st(ST_FULL_RESET);
    endtask : t_midrst

    task automatic t_rx;
        logic [1:0] v;
        logic [1:0] p;
        p = 2'h0;
        for (int i = 0; i < 24; i++) begin
            v = (i == 16) ? ~p : 2'(i) ^ 2'(i >> 2);
            rx_sym(i == 16, v, i >= 12 && i != 16);
            if (i == 16) chk_val("rx held", 12'(p), 12'(rx_data));
            p = v;
        end
    endtask : t_rx

    task automatic t_tone;
        int n;
        lsse_tx_t e;
        @(posedge clock);
        service_request <= 1'b1;
        @(posedge clock);
        service_request <= 1'b0;
        #1;
        chk_st(ST_WAKE_TONE);
        chk_val("line before tone", 12'h000, 12'(tx_line));
        wait_strobe(n);
        for (int i = 0; i < 10; i++) begin
            e = '{1'b1, (i % 8 < 4) ? SYM_POS3 : SYM_NEG3};
            chk_val("tone symbol", 12'(e), 12'(tx_line));
            @(posedge clock);
            tx_slot <= lsse_slot_t'(i);
            tx_fw <= 2'(i);
            tx_user <= ~2'(i);
            tx_ovh <= 2'(i >> 1);
            service_request <= (i == 5);
            wait_strobe(n);
            chk_val("symbol spacing", 12'(SYM_CYCLES - 1), 12'(n));
        end
        chk_st(ST_WAKE_TONE);
    endtask : t_tone

    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        t_reset;
        t_eoc_codes;
        t_eoc_refuse;
        t_midrst;
        t_rx;
        t_tone;
        conclude;
    end

    initial begin
        #300000;
        err_total++;
        conclude;
    end
endmodule : lsse_customer_terminal_tb
